// *** logic/flash_address_and_content_protection.sv ***
// Purpose: flash address registers, content zones and read protection
// Assumes: register port and requests come from logic on core_clk
// Notes: every register write needs the timed-access unlock level
// Notes: the port address is decoded once and shared by writes and reads
`timescale 1ns/1ps

module flash_address_and_content_protection (
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // asynchronous reset, any source
  input wire logic [15:0] reg_addr, // register address
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic ta_unlock, // timed-access window open
  output logic [7:0] reg_rdata, // register read data
  input wire logic cmd_valid, // flash command issued
  input wire logic cmd_modify, // command is erase or write
  output logic cmd_go, // command may run
  output logic cmd_fail, // command aborted
  output logic [16:0] flash_addr, // composed flash address
  input wire logic rd_valid, // program or byte read data valid
  input wire logic [16:0] rd_addr, // address of that read
  input wire logic [7:0] rd_raw, // byte from the array
  output logic rd_data_valid, // filtered byte valid
  output logic [7:0] rd_data, // filtered byte
  output logic read_protect_on // range programmed
);
  prot_link_if link ();

  logic [7:0] addr_low;
  logic [7:0] addr_high;
  logic addr_msb;
  logic [7:0] lower_zone_bound;
  logic [7:0] upper_zone_bound;
  logic [7:0] read_protect_range_low;
  logic [6:0] range_high;
  logic range_update_enable;
  logic range_locked;
  logic wr_ok;
  logic range_write;
  logic [7:0] next_range_low;
  logic [6:0] next_range_high;
  logic [7:0] next_rdata;
  logic [6:0] reg_sel;
  logic [16:0] cmd_target;
  logic wr_addr_low;
  logic wr_addr_high;
  logic wr_addr_msb;
  logic wr_lower_bound;
  logic wr_upper_bound;
  logic wr_range_low;
  logic wr_range_high;
  logic range_write_low;
  logic range_write_high;
  logic range_any;
  logic enable_request;
  logic range_programmed;
  logic zone_block;
  logic [7:0] filtered_byte;

  // one-hot decode of the register port address, shared by writes and reads
  function automatic logic [6:0] reg_select(input logic [15:0] a);
    logic [6:0] sel;
    sel = 7'h00;
    case (a)
      flash_prot_pkg::OFS_ADDR_LOW: begin
        sel[0] = 1'b1;
      end
      flash_prot_pkg::OFS_ADDR_HIGH: begin
        sel[1] = 1'b1;
      end
      flash_prot_pkg::OFS_ADDR_MSB: begin
        sel[2] = 1'b1;
      end
      flash_prot_pkg::OFS_LOWER_BOUND: begin
        sel[3] = 1'b1;
      end
      flash_prot_pkg::OFS_UPPER_BOUND: begin
        sel[4] = 1'b1;
      end
      flash_prot_pkg::OFS_RANGE_LOW: begin
        sel[5] = 1'b1;
      end
      flash_prot_pkg::OFS_RANGE_HIGH: begin
        sel[6] = 1'b1;
      end
      default: begin
        sel = 7'h00;
      end
    endcase
    return sel;
  endfunction : reg_select

  // decoded register select
  assign reg_sel = reg_select(reg_addr);

  // composed 17-bit flash address
  assign cmd_target = {addr_msb, addr_high, addr_low};

  // checker sees the live settings
  assign link.cmd_addr = cmd_target;
  assign link.rd_addr = rd_addr;
  assign link.lower_bound = lower_zone_bound;
  assign link.upper_bound = upper_zone_bound;
  assign link.range_bits = {range_high, read_protect_range_low};

  prot_check u_check (
    .link(link)
  );

  // a write counts only inside the unlock window
  assign wr_ok = reg_wr && ta_unlock;

  // per-register write strobes, only inside the unlock window
  assign wr_addr_low = wr_ok && reg_sel[0];
  assign wr_addr_high = wr_ok && reg_sel[1];
  assign wr_addr_msb = wr_ok && reg_sel[2];
  assign wr_lower_bound = wr_ok && reg_sel[3];
  assign wr_upper_bound = wr_ok && reg_sel[4];
  assign wr_range_low = wr_ok && reg_sel[5];
  assign wr_range_high = wr_ok && reg_sel[6];

  // address low byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_low <= flash_prot_pkg::RST_ADDR;
    end else if (wr_addr_low) begin
      addr_low <= reg_wdata;
    end
  end

  // address high byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_high <= flash_prot_pkg::RST_ADDR;
    end else if (wr_addr_high) begin
      addr_high <= reg_wdata;
    end
  end

  // address bit 16, other bits of the byte ignored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_msb <= 1'b0;
    end else if (wr_addr_msb) begin
      addr_msb <= reg_wdata[flash_prot_pkg::ADDR_MSB_BIT];
    end
  end

  // composed address copy for the array sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_addr <= 17'h0_0000;
    end else begin
      flash_addr <= cmd_target;
    end
  end

  // lower zone bound, starts fully protecting
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lower_zone_bound <= flash_prot_pkg::RST_LOWER_BOUND;
    end else if (wr_lower_bound) begin
      lower_zone_bound <= reg_wdata;
    end
  end

  // upper zone bound, starts fully protecting
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_zone_bound <= flash_prot_pkg::RST_UPPER_BOUND;
    end else if (wr_upper_bound) begin
      upper_zone_bound <= reg_wdata;
    end
  end

  // a write that may change the range bits
  assign range_write = range_update_enable && (wr_range_low || wr_range_high);

  // granted range writes, one per register
  assign range_write_low = range_write && wr_range_low;
  assign range_write_high = range_write && wr_range_high;

  // next range values: or-in only, writes of zero change nothing
  always_comb begin
    next_range_low = read_protect_range_low;
    next_range_high = range_high;
    if (range_write_low) begin
      next_range_low = read_protect_range_low | reg_wdata;
    end
    if (range_write_high) begin
      next_range_high = range_high | reg_wdata[6:0];
    end
  end

  // low range bits, cleared only by reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_protect_range_low <= flash_prot_pkg::RST_RANGE;
    end else begin
      read_protect_range_low <= next_range_low;
    end
  end

  // high range bits, cleared only by reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      range_high <= 7'h00;
    end else begin
      range_high <= next_range_high;
    end
  end

  // any range bit standing or about to be set
  assign range_any = (next_range_low != 8'h00) || (next_range_high != 7'h00);

  // lock once any range bit has been set
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      range_locked <= 1'b0;
    end else if (range_any) begin
      range_locked <= 1'b1;
    end
  end

  // software asks for the update enable with bit 7 of the high range register
  assign enable_request = wr_range_high && reg_wdata[flash_prot_pkg::UPDATE_EN_BIT];

  // update enable: set by 80 write, dropped for good after a range is set
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      range_update_enable <= 1'b0;
    end else if (range_locked || range_any) begin
      range_update_enable <= 1'b0;
    end else if (enable_request) begin
      range_update_enable <= 1'b1;
    end
  end

  // some range bit is programmed
  assign range_programmed = (read_protect_range_low != 8'h00) || (range_high != 7'h00);

  // read protection active flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_protect_on <= 1'b0;
    end else begin
      read_protect_on <= range_programmed;
    end
  end

  // register read mux, unmapped reads give zero
  always_comb begin
    next_rdata = flash_prot_pkg::UNMAPPED_READ;
    case (reg_sel)
      7'h01: begin
        next_rdata = addr_low;
      end
      7'h02: begin
        next_rdata = addr_high;
      end
      7'h04: begin
        next_rdata = flash_prot_pkg::MSB_READ_ONES | {7'h00, addr_msb};
      end
      7'h08: begin
        next_rdata = lower_zone_bound;
      end
      7'h10: begin
        next_rdata = upper_zone_bound;
      end
      7'h20: begin
        next_rdata = read_protect_range_low;
      end
      7'h40: begin
        next_rdata = {range_update_enable, range_high};
      end
      default: begin
        next_rdata = flash_prot_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // read data register, held between reads
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // erase or write aimed into a protection zone
  assign zone_block = cmd_modify && link.zone_hit;

  // go pulse a cycle after issue
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_go <= 1'b0;
    end else begin
      cmd_go <= cmd_valid && !zone_block;
    end
  end

  // fail pulse a cycle after issue
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_fail <= 1'b0;
    end else begin
      cmd_fail <= cmd_valid && zone_block;
    end
  end

  // byte as the program sees it, blank inside the protected range
  assign filtered_byte = link.read_hit ? flash_prot_pkg::READ_BLANK : rd_raw;

  // filtered byte valid, one pulse per read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_valid <= 1'b0;
    end else begin
      rd_data_valid <= rd_valid;
    end
  end

  // filtered byte, held between reads
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else if (rd_valid) begin
      rd_data <= filtered_byte;
    end
  end
endmodule : flash_address_and_content_protection

// *** logic/flash_prot_pkg.sv ***
// Purpose: shared constants of the flash address and protection block
// Assumes: 8-bit register port, 17-bit flash byte address
// Notes: offsets are the byte addresses of the register port
package flash_prot_pkg;
  // widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 16;
  localparam int RANGE_W = 15;
  localparam int RANGE_HIGH_W = 7;
  localparam int UNIT_W = 8;
  localparam int BLOCK_W = 4;
  // register offsets
  localparam logic [15:0] OFS_ADDR_MSB = 16'ha012;
  localparam logic [15:0] OFS_RANGE_LOW = 16'ha013;
  localparam logic [15:0] OFS_RANGE_HIGH = 16'ha014;
  localparam logic [15:0] OFS_ADDR_HIGH = 16'ha022;
  localparam logic [15:0] OFS_ADDR_LOW = 16'ha023;
  localparam logic [15:0] OFS_LOWER_BOUND = 16'ha025;
  localparam logic [15:0] OFS_UPPER_BOUND = 16'ha026;
  // reset values
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_LOWER_BOUND = 8'hff;
  localparam logic [7:0] RST_UPPER_BOUND = 8'h00;
  localparam logic [7:0] RST_RANGE = 8'h00;
  // field positions and fixed values
  localparam int ADDR_MSB_BIT = 0;
  localparam int UPDATE_EN_BIT = 7;
  localparam int ZONE_UNIT_LSB = 9;
  localparam int READ_BLOCK_LSB = 13;
  localparam logic [7:0] MSB_READ_ONES = 8'h3c;
  localparam logic [7:0] READ_BLANK = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : flash_prot_pkg

// *** logic/prot_check.sv ***
// Purpose: decodes content protection zones and read protection range
// Assumes: settings are stable register values
// Notes: combinational; the owner registers the results
`timescale 1ns/1ps
module prot_check (
  prot_link_if.check link // settings in, hit flags out
);
  logic [7:0] unit;
  logic [3:0] start_block;
  logic [3:0] rd_block;

  // first block index protected, 0 when no range bit is set
  function automatic logic [3:0] first_block(input logic [14:0] bits);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 14; i >= 0; i--) begin
      if (bits[i]) begin
        idx = 4'(i + 1); // lower index overrides higher
      end
    end
    return idx;
  endfunction : first_block

  // 512-byte unit of the command target
  assign unit = link.cmd_addr[16:flash_prot_pkg::ZONE_UNIT_LSB];
  // lower zone units below bound, upper zone units above bound
  assign link.zone_hit = (unit < link.lower_bound) || (unit > link.upper_bound);
  // 8KB block of the read address
  assign rd_block = link.rd_addr[16:flash_prot_pkg::READ_BLOCK_LSB];
  assign start_block = first_block(link.range_bits);
  assign link.read_hit = (start_block != 4'h0) && (rd_block >= start_block);
endmodule : prot_check

// *** logic/prot_link_if.sv ***
// Purpose: carries addresses and protection settings to the checker
// Assumes: one clock domain, purely combinational results
// Notes: top drives settings, checker returns hit flags
`timescale 1ns/1ps
interface prot_link_if;
  logic [16:0] cmd_addr;
  logic [16:0] rd_addr;
  logic [7:0] lower_bound;
  logic [7:0] upper_bound;
  logic [14:0] range_bits;
  logic zone_hit;
  logic read_hit;
  modport owner (output cmd_addr, rd_addr, lower_bound, upper_bound, range_bits, input zone_hit, read_hit);
  modport check (input cmd_addr, rd_addr, lower_bound, upper_bound, range_bits, output zone_hit, read_hit);
endinterface : prot_link_if

// *** sim/flash_array_model.sv ***
// Purpose: flash array model giving bytes for program reads
// Assumes: stored byte is a fixed function of the address
// Notes: shows a flipping pattern while no read is valid
`timescale 1ns/1ps
module flash_array_model (
  input wire logic core_clk, // clock
  input wire logic rd_valid, // read valid
  input wire logic [16:0] rd_addr, // read address
  output logic [7:0] rd_raw // stored byte
);
  logic [7:0] idle_flip = 8'ha5;
  // idle pattern flips so a stale byte never looks valid
  always @(posedge core_clk) begin
    idle_flip <= ~idle_flip;
  end
  // array contents derived from the address
  assign rd_raw = rd_valid ? (rd_addr[7:0] ^ rd_addr[16:9] ^ 8'h5a) : idle_flip;
endmodule : flash_array_model

// *** sim/flash_prot_assertions.sv ***
// Purpose: port checks of the flash protection block
// Assumes: one clock, reset active high
// Notes: bound to the top module
`timescale 1ns/1ps
module flash_prot_assertions (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic cmd_valid, // command issued
  input wire logic cmd_modify, // erase or write
  input wire logic cmd_go, // command runs
  input wire logic cmd_fail, // command aborted
  input wire logic rd_valid, // array byte valid
  input wire logic [16:0] rd_addr, // its address
  input wire logic [7:0] rd_raw, // array byte
  input wire logic rd_data_valid, // filtered valid
  input wire logic [7:0] rd_data, // filtered byte
  input wire logic read_protect_on // range set
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // command answers
  chk_cmd_one_answer: assert property (cmd_valid |=> cmd_go != cmd_fail)
    else $error("command answer not single");
  chk_cmd_no_answer: assert property (!cmd_valid |=> !cmd_go && !cmd_fail)
    else $error("answer without command");
  chk_read_cmd_go: assert property (cmd_valid && !cmd_modify |=> cmd_go)
    else $error("read command refused");
  // read filter
  chk_filter_valid: assert property (rd_valid |=> rd_data_valid)
    else $error("filtered byte missing");
  chk_filter_idle: assert property (!rd_valid |=> !rd_data_valid && $stable(rd_data))
    else $error("filter moved without read");
  chk_low_reads_pass: assert property (rd_valid && rd_addr[16:13] == 4'h0 |=> rd_data == $past(rd_raw))
    else $error("low read altered");
  chk_top_reads_blank: assert property (rd_valid && read_protect_on && rd_addr[16:13] == 4'hf |=> rd_data == 8'h00)
    else $error("protected top read leaked");
  chk_protect_sticky: assert property (read_protect_on |=> read_protect_on)
    else $error("read protection dropped");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : flash_prot_assertions
bind flash_address_and_content_protection flash_prot_assertions chk (.core_clk, .sys_rst, .reg_rd, .reg_rdata,
  .cmd_valid, .cmd_modify, .cmd_go, .cmd_fail, .rd_valid, .rd_addr, .rd_raw, .rd_data_valid, .rd_data,
  .read_protect_on);

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the flash protection block
// Assumes: inputs change at the falling edge
// Notes: expected register state kept in lo, hi and rng
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ta_unlock = 1;
  logic cmd_valid = 0, cmd_modify = 0, rd_valid = 0, cmd_go, cmd_fail, rd_data_valid, read_protect_on;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_raw, rd_data, lo, hi;
  logic [16:0] rd_addr = 17'h0_0000, flash_addr, a, x;
  logic [14:0] rng;
  int err_count = 0, checked = 0;
  flash_address_and_content_protection dut (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .ta_unlock, .reg_rdata, .cmd_valid, .cmd_modify, .cmd_go, .cmd_fail, .flash_addr, .rd_valid, .rd_addr,
    .rd_raw, .rd_data_valid, .rd_data, .read_protect_on);
  flash_array_model fa (.core_clk, .rd_valid, .rd_addr, .rd_raw);
  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // lowest set range bit decides the blanked start
  function automatic logic blocked(input logic [16:0] y);
    for (int i = 0; i < 15; i++) begin
      if (rng[i]) return y[16:13] > i;
    end
    return 1'b0;
  endfunction : blocked
  task automatic cmp(input string n, input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic rst();
    sys_rst = 1;
    lo = 8'hff;
    hi = 8'h00;
    rng = 15'h0000;
    repeat (2) @(negedge core_clk);
    sys_rst = 0;
  endtask : rst
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk) reg_wr = 0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    reg_addr = ad;
    reg_rd = 1;
    @(negedge core_clk) reg_rd = 0;
    cmp("reg_rdata", 17'(e), 17'(reg_rdata));
    @(negedge core_clk);
  endtask : rd
  task automatic setad(input logic [16:0] y);
    a = y;
    wr(16'ha012, {7'h00, y[16]});
    wr(16'ha022, y[15:8]);
    wr(16'ha023, y[7:0]);
  endtask : setad
  task automatic cmd(input logic m);
    logic f;
    f = m && (a[16:9] < lo || a[16:9] > hi);
    cmd_modify = m;
    cmd_valid = 1;
    @(negedge core_clk) cmd_valid = 0;
    cmp("cmd_fail", 17'(f), 17'(cmd_fail));
    cmp("cmd_go", 17'(!f), 17'(cmd_go));
    @(negedge core_clk);
  endtask : cmd
  task automatic rdf(input logic [16:0] y);
    rd_addr = y;
    rd_valid = 1;
    @(negedge core_clk) rd_valid = 0;
    cmp("rd_data", blocked(y) ? 17'h0_0000 : 17'(y[7:0] ^ y[16:9] ^ 8'h5a), 17'(rd_data));
    @(negedge core_clk);
  endtask : rdf
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h4fabc197));
    rst();
    rd(16'ha012, 8'h3c);
    rd(16'ha013, 8'h00);
    rd(16'ha014, 8'h00);
    rd(16'ha022, 8'h00);
    rd(16'ha025, 8'hff);
    rd(16'ha026, 8'h00);
    rd(16'ha020, 8'h00);
    setad(17'h1_fe00);
    cmd(1);
    cmd(0);
    ta_unlock = 0;
    wr(16'ha025, 8'h00);
    ta_unlock = 1;
    rd(16'ha025, 8'hff);
    $display("test reset and lock done");
    for (int k = 0; k < 24; k++) begin
      lo = 8'($urandom_range(0, 128));
      hi = 8'($urandom_range(128, 255));
      wr(16'ha025, lo);
      wr(16'ha026, hi);
      x = 17'($urandom);
      if (k % 3 == 0) x[16:9] = lo - 8'(k % 2);
      if (k % 3 == 1) x[16:9] = hi + 8'(k % 2);
      setad(x);
      rd(16'ha012, 8'h3c | {7'h00, x[16]});
      cmp("flash_addr", x, flash_addr);
      cmd(1);
    end
    $display("test zones done");
    rdf(17'h1_e000);
    wr(16'ha013, 8'h01);
    rd(16'ha013, 8'h00);
    wr(16'ha014, 8'h80);
    rd(16'ha014, 8'h80);
    wr(16'ha013, 8'h04);
    rng = 15'h0004;
    rd(16'ha014, 8'h00);
    cmp("read_protect_on", 17'h0_0001, 17'(read_protect_on));
    wr(16'ha014, 8'h80);
    wr(16'ha013, 8'h00);
    wr(16'ha013, 8'h01);
    rd(16'ha013, 8'h04);
    rd(16'ha014, 8'h00);
    rdf(17'h0_5fff);
    rdf(17'h0_6000);
    rdf(17'h1_ffff);
    rdf(17'h0_1fff);
    // reads above the start only probe the filter; the bench never runs code from there
    for (int k = 0; k < 16; k++) begin
      rdf(17'($urandom));
    end
    $display("test read protect done");
    rst();
    rd(16'ha013, 8'h00);
    cmp("read_protect_on", 17'h0_0000, 17'(read_protect_on));
    wr(16'ha014, 8'h80);
    wr(16'ha014, 8'h81);
    rng = 15'h0100;
    rd(16'ha014, 8'h01);
    rdf(17'h1_1fff);
    rdf(17'h1_2000);
    $display("test second reset done");
    complete_run();
  end
endmodule : testbench
